// >>> dwcs_sequencer.sv
/*
  write-check sequencer with ahb-lite register slave, two sector buffers,
  serializer, comparator and 32-bit ecc check.
  assumes clock at 50 mhz, drive pins asynchronous, host-side pins on clock.
*/
// The register offsets and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dwcs_regs.svh"

module dwcs_sequencer #(
  parameter int GAP_PULSES = `DWCS_GAP_PULSES,
  parameter logic [31:0] ECC_POLY = `DWCS_ECC_POLY
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic drive_servo_clock,
  input wire logic drive_read_clock,
  input wire logic drive_read_data,
  input wire logic sector_found,
  input wire logic drive_ready,
  input wire logic sector_transfer_grant,
  input wire logic bus_request_ack,
  output logic bus_request_level5,
  output logic sector_transfer_request,
  output logic read_enable_tag,
  output dwcs_pkg::dwcs_clksel_type shift_clock_sel,
  output dwcs_pkg::dwcs_clksel_type sequencer_clock_sel,
  output logic check_byte_load,
  output logic shift_out_bit,
  output logic [31:0] function_timer
);

  // the gap wait counter is eight bits wide
  if (GAP_PULSES < 1 || GAP_PULSES > 255) begin : g_gap_check
    $error("GAP_PULSES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive pin synchronisers
  logic [4:0] pin_in;
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic [1:0] clk_d_r;
  assign pin_in = {drive_ready, sector_found, drive_read_data, drive_read_clock,
                   drive_servo_clock};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge clock) begin
        sync1_r[gi] <= rst ? 1'b0 : pin_in[gi];
        sync2_r[gi] <= rst ? 1'b0 : sync1_r[gi];
      end
    end
  endgenerate
  always_ff @(posedge clock) begin
    clk_d_r <= rst ? 2'b00 : {sync2_r[1], sync2_r[0]};
  end
  wire servo_edge = sync2_r[0] & ~clk_d_r[0];
  wire read_edge = sync2_r[1] & ~clk_d_r[1];
  wire read_bit = sync2_r[2];
  logic found_d_r;
  always_ff @(posedge clock) begin
    found_d_r <= rst ? 1'b0 : sync2_r[3];
  end
  wire found_rise = sync2_r[3] & ~found_d_r;
  wire drv_rdy = sync2_r[4];

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave
  dwcs_pkg::dwcs_aphase_type aph_r;
  wire aph_take = hsel & hready & htrans[1];
  wire wr_csr = aph_r.valid & aph_r.write & (aph_r.addr == `DWCS_OFS_CSR);
  wire wr_buf = aph_r.valid & aph_r.write & (aph_r.addr == `DWCS_OFS_BUF);
  wire wr_dad = aph_r.valid & aph_r.write & (aph_r.addr == `DWCS_OFS_DADDR);
  always_ff @(posedge clock) begin
    if (rst) begin
      aph_r <= '0;
    end else begin
      aph_r <= '{valid: aph_take, write: hwrite, addr: haddr[7:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and state
  dwcs_pkg::dwcs_state_type st_r;
  dwcs_pkg::dwcs_state_type st_nxt;
  logic command_ready_bit_r;
  logic ie_r;
  logic cmp_r;
  logic ecc_err_r;
  logic dlt_r;
  logic req_r;
  logic irq_r;
  logic dsel_r;
  logic hsel_buf_r;
  logic [1:0] loaded_r;
  logic [8:0] hptr_r;
  logic [31:0] daddr_r;
  logic [31:0] timer_r;
  logic [7:0] cnt_r;
  logic [8:0] addr_r;
  logic [2:0] bit_r;
  logic [7:0] shreg_r;
  logic [7:0] hunt_r;
  logic [7:0] pattern_r;
  logic mis_r;
  logic [31:0] gen_ecc_r;
  logic [31:0] rcv_ecc_r;
  logic [4:0] ecc_cnt_r;
  logic gate_r;
  logic ld_r;
  dwcs_pkg::dwcs_clksel_type shclk_r;
  dwcs_pkg::dwcs_clksel_type sqclk_r;
  logic [31:0] rdata_r;
  logic [7:0] buf_mem [0:2*`DWCS_SECTOR_BYTES-1];

  wire [7:0] cur_byte = buf_mem[{dsel_r, addr_r}];
  wire [7:0] hunt_nxt = {read_bit, hunt_r[7:1]};
  wire sync_hit = (st_r == dwcs_pkg::ST_HUNT) & read_edge & (hunt_nxt == pattern_r);
  wire in_data = (st_r == dwcs_pkg::ST_DATA) & read_edge;
  wire last_bit = (bit_r == 3'd7);
  // the address runs one byte ahead and wraps to zero during the last byte
  wire last_byte = (addr_r == 9'h000);
  wire ecc_fb = gen_ecc_r[31] ^ shreg_r[0];
  wire [31:0] ecc_upd = {gen_ecc_r[30:0], 1'b0} ^ (ecc_fb ? ECC_POLY : 32'h0000_0000);
  wire ecc_last = in_data & last_bit & last_byte;
  wire start_cmd = wr_csr & ~hwdata[`DWCS_CSR_COMMAND_READY_BIT] & (st_r == dwcs_pkg::ST_IDLE);
  wire late_stop = (st_r == dwcs_pkg::ST_BUFCK) & ~loaded_r[dsel_r];
  wire ecc_stop = (st_r == dwcs_pkg::ST_ECCMP) & (rcv_ecc_r != gen_ecc_r);
  wire end_stop = (st_r == dwcs_pkg::ST_NEXT) & command_ready_bit_r;
  wire done_evt = late_stop | ecc_stop | end_stop;
  wire fill_last = wr_buf & (hptr_r == 9'(`DWCS_SECTOR_BYTES - 1));
  wire consume = (st_r == dwcs_pkg::ST_NEXT);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      dwcs_pkg::ST_IDLE: begin
        if (start_cmd) begin
          st_nxt = dwcs_pkg::ST_FIND;
        end
      end
      dwcs_pkg::ST_FIND: begin
        if (found_rise) begin
          st_nxt = dwcs_pkg::ST_BUFCK;
        end
      end
      dwcs_pkg::ST_BUFCK: begin
        st_nxt = late_stop ? dwcs_pkg::ST_IDLE : dwcs_pkg::ST_GAP;
      end
      dwcs_pkg::ST_GAP: begin
        if (servo_edge && cnt_r == 8'(GAP_PULSES - 1)) begin
          st_nxt = dwcs_pkg::ST_LOCK;
        end
      end
      dwcs_pkg::ST_LOCK: begin
        if (servo_edge && cnt_r == 8'(`DWCS_LOCK_PULSES - 1)) begin
          st_nxt = dwcs_pkg::ST_HUNT;
        end
      end
      dwcs_pkg::ST_HUNT: begin
        if (sync_hit) begin
          st_nxt = dwcs_pkg::ST_DATA;
        end
      end
      dwcs_pkg::ST_DATA: begin
        if (ecc_last) begin
          st_nxt = dwcs_pkg::ST_ECCIN;
        end
      end
      dwcs_pkg::ST_ECCIN: begin
        if (read_edge && ecc_cnt_r == 5'(`DWCS_ECC_BITS - 1)) begin
          st_nxt = dwcs_pkg::ST_ECCMP;
        end
      end
      dwcs_pkg::ST_ECCMP: begin
        st_nxt = ecc_stop ? dwcs_pkg::ST_IDLE : dwcs_pkg::ST_XREQ;
      end
      dwcs_pkg::ST_XREQ: begin
        if (sector_transfer_grant) begin
          st_nxt = dwcs_pkg::ST_NEXT;
        end
      end
      dwcs_pkg::ST_NEXT: begin
        st_nxt = command_ready_bit_r ? dwcs_pkg::ST_IDLE : dwcs_pkg::ST_DRDY;
      end
      dwcs_pkg::ST_DRDY: begin
        if (drv_rdy) begin
          st_nxt = dwcs_pkg::ST_FIND;
        end
      end
      default: begin
        st_nxt = dwcs_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    st_r <= rst ? dwcs_pkg::ST_IDLE : st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and status bits; hardware set wins over software clear
  always_ff @(posedge clock) begin
    if (rst) begin
      command_ready_bit_r <= 1'b1;
      ie_r <= 1'b0;
      hsel_buf_r <= 1'b0;
      dlt_r <= 1'b0;
      ecc_err_r <= 1'b0;
    end else begin
      if (wr_csr) begin
        ie_r <= hwdata[`DWCS_CSR_IE];
        hsel_buf_r <= hwdata[`DWCS_CSR_HSEL];
      end
      command_ready_bit_r <= done_evt | (wr_csr ? hwdata[`DWCS_CSR_COMMAND_READY_BIT] : command_ready_bit_r);
      dlt_r <= late_stop | (start_cmd ? 1'b0 : dlt_r);
      ecc_err_r <= ecc_stop | (start_cmd ? 1'b0 : ecc_err_r);
    end
  end

  // bus request held until acknowledged; one per completion while ie is set
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (done_evt & ie_r) | (irq_r & ~bus_request_ack);
    end
  end

  // transfer request, cleared by grant
  always_ff @(posedge clock) begin
    if (rst) begin
      req_r <= 1'b0;
    end else begin
      req_r <= ((st_r == dwcs_pkg::ST_ECCMP) & ~ecc_stop)
               | (req_r & ~sector_transfer_grant);
    end
  end

  // buffer fill by host, loaded flags, buffer swap
  always_ff @(posedge clock) begin
    if (wr_buf) begin
      buf_mem[{hsel_buf_r, hptr_r}] <= hwdata[7:0];
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      hptr_r <= 9'h000;
      loaded_r <= 2'b00;
      dsel_r <= 1'b0;
    end else begin
      if (wr_csr) begin
        hptr_r <= 9'h000;
      end else if (wr_buf) begin
        hptr_r <= hptr_r + 9'h001;
      end
      loaded_r[0] <= (fill_last & ~hsel_buf_r) | (loaded_r[0] & ~(consume & ~dsel_r));
      loaded_r[1] <= (fill_last & hsel_buf_r) | (loaded_r[1] & ~(consume & dsel_r));
      if (consume) begin
        dsel_r <= ~dsel_r;
      end
    end
  end

  // disk address and function timer
  always_ff @(posedge clock) begin
    if (rst) begin
      daddr_r <= 32'h0000_0000;
      timer_r <= 32'h0000_0000;
    end else begin
      if (wr_dad) begin
        daddr_r <= hwdata;
      end else if (consume && !command_ready_bit_r) begin
        daddr_r <= daddr_r + 32'h0000_0001;
      end
      timer_r <= (start_cmd | (consume & ~command_ready_bit_r)) ? 32'h0000_0000 : timer_r + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock selection and read enable tag
  always_ff @(posedge clock) begin
    if (rst) begin
      shclk_r <= dwcs_pkg::CLK_CPU;
      sqclk_r <= dwcs_pkg::CLK_CPU;
      gate_r <= 1'b1;
    end else begin
      if (late_stop || (st_r == dwcs_pkg::ST_ECCIN && st_nxt == dwcs_pkg::ST_ECCMP)) begin
        shclk_r <= dwcs_pkg::CLK_CPU;
        sqclk_r <= dwcs_pkg::CLK_CPU;
      end else if (st_r == dwcs_pkg::ST_BUFCK) begin
        shclk_r <= dwcs_pkg::CLK_SERVO;
        sqclk_r <= dwcs_pkg::CLK_SERVO;
      end else if (st_r == dwcs_pkg::ST_LOCK && st_nxt == dwcs_pkg::ST_HUNT) begin
        shclk_r <= dwcs_pkg::CLK_READ;
      end else if (sync_hit) begin
        sqclk_r <= dwcs_pkg::CLK_READ;
      end
      if (st_r == dwcs_pkg::ST_BUFCK && !late_stop) begin
        gate_r <= 1'b0;
      end else if (st_r == dwcs_pkg::ST_GAP && st_nxt == dwcs_pkg::ST_LOCK) begin
        gate_r <= 1'b1;
      end
    end
  end

  // servo pulse counter for gap and lock waits
  always_ff @(posedge clock) begin
    if (rst || st_r != st_nxt) begin
      cnt_r <= 8'h00;
    end else if (servo_edge) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serializer, comparator, ecc
  always_ff @(posedge clock) begin
    if (rst) begin
      addr_r <= 9'h000;
      bit_r <= 3'd0;
      shreg_r <= 8'h00;
      hunt_r <= 8'h00;
      pattern_r <= 8'h00;
      mis_r <= 1'b0;
      cmp_r <= 1'b0;
      ld_r <= 1'b0;
    end else begin
      ld_r <= sync_hit;
      if (late_stop) begin
        cmp_r <= 1'b0;
      end
      if (st_r == dwcs_pkg::ST_LOCK && st_nxt == dwcs_pkg::ST_HUNT) begin
        addr_r <= 9'h000;
        shreg_r <= cur_byte;
        cmp_r <= 1'b0;
        mis_r <= 1'b0;
        pattern_r <= `DWCS_SYNC_BYTE;
        hunt_r <= 8'h00;
        bit_r <= 3'd0;
      end else if (st_r == dwcs_pkg::ST_HUNT && read_edge) begin
        hunt_r <= hunt_nxt;
        if (sync_hit) begin
          shreg_r <= cur_byte;
          addr_r <= addr_r + 9'h001;
        end
      end else if (in_data) begin
        mis_r <= mis_r | (shreg_r[0] ^ read_bit);
        bit_r <= bit_r + 3'd1;
        if (last_bit) begin
          shreg_r <= cur_byte;
          addr_r <= addr_r + 9'h001;
        end else begin
          shreg_r <= {1'b0, shreg_r[7:1]};
        end
        if (ecc_last) begin
          cmp_r <= ~(mis_r | (shreg_r[0] ^ read_bit));
        end
      end else if (st_r == dwcs_pkg::ST_ECCMP && !ecc_stop) begin
        addr_r <= 9'h000;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst || sync_hit) begin
      gen_ecc_r <= 32'h0000_0000;
      ecc_cnt_r <= 5'd0;
      rcv_ecc_r <= 32'h0000_0000;
    end else if (in_data) begin
      gen_ecc_r <= ecc_upd;
    end else if (st_r == dwcs_pkg::ST_ECCIN && read_edge) begin
      rcv_ecc_r <= {rcv_ecc_r[30:0], read_bit};
      ecc_cnt_r <= ecc_cnt_r + 5'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data path
  wire [31:0] csr_view = {22'h00_0000, loaded_r, hsel_buf_r, dsel_r, req_r, dlt_r,
                          ecc_err_r, cmp_r, ie_r, command_ready_bit_r};
  wire [31:0] rd_mux = (haddr[7:0] == `DWCS_OFS_CSR) ? csr_view :
                       (haddr[7:0] == `DWCS_OFS_BUF) ? {23'h00_0000, hptr_r} :
                       (haddr[7:0] == `DWCS_OFS_DADDR) ? daddr_r : 32'h0000_0000;
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (aph_take && !hwrite) begin
      rdata_r <= rd_mux;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;
  assign bus_request_level5 = irq_r;
  assign sector_transfer_request = req_r;
  assign read_enable_tag = gate_r;
  assign shift_clock_sel = shclk_r;
  assign sequencer_clock_sel = sqclk_r;
  assign check_byte_load = ld_r;
  assign shift_out_bit = shreg_r[0];
  assign function_timer = timer_r;

endmodule : dwcs_sequencer
`default_nettype wire

// >>> dwcs_regs.svh
/*
  register offsets, field positions, reset values and timing counts of the
  disk write-check sequencer.
  assumes a 32-bit bus with byte addresses, one register per aligned word.
*/
`ifndef DWCS_REGS_SVH
`define DWCS_REGS_SVH

`define DWCS_OFS_CSR 8'h00
`define DWCS_OFS_BUF 8'h04
`define DWCS_OFS_DADDR 8'h08
`define DWCS_CSR_COMMAND_READY_BIT 0
`define DWCS_CSR_IE 1
`define DWCS_CSR_CMP 2
`define DWCS_CSR_ECC 3
`define DWCS_CSR_DLT 4
`define DWCS_CSR_REQ 5
`define DWCS_CSR_DSEL 6
`define DWCS_CSR_HSEL 7
`define DWCS_CSR_LDA 8
`define DWCS_CSR_LDB 9
`define DWCS_CSR_RESET 32'h0000_0001
`define DWCS_SYNC_BYTE 8'h19
`define DWCS_LOCK_PULSES 88
`define DWCS_SECTOR_BYTES 512
`define DWCS_ECC_BITS 32
`define DWCS_GAP_PULSES 16
`define DWCS_ECC_POLY 32'h0000_008D

`endif

// >>> dwcs_pkg.sv
/*
  types of the disk write-check sequencer.
  assumes dwcs_regs.svh supplies the numeric pattern_constant.
*/
package dwcs_pkg;
  typedef enum logic [11:0] {
    ST_IDLE  = 12'h001,
    ST_FIND  = 12'h002,
    ST_BUFCK = 12'h004,
    ST_GAP   = 12'h008,
    ST_LOCK  = 12'h010,
    ST_HUNT  = 12'h020,
    ST_DATA  = 12'h040,
    ST_ECCIN = 12'h080,
    ST_ECCMP = 12'h100,
    ST_XREQ  = 12'h200,
    ST_NEXT  = 12'h400,
    ST_DRDY  = 12'h800
  } dwcs_state_type;

  typedef enum logic [1:0] {
    CLK_CPU   = 2'h0,
    CLK_SERVO = 2'h1,
    CLK_READ  = 2'h2
  } dwcs_clksel_type;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } dwcs_aphase_type;
endpackage : dwcs_pkg

// >>> dwcs_drive_model.sv
/* behavioural drive: free servo clock, framed read clock and nrz data.
   assumes the sequencer drops, then raises, the read gate once per sector. */
`timescale 1ns/1ps
`default_nettype none
`include "dwcs_regs.svh"
module dwcs_drive_model #(
  parameter logic [31:0] ECC_POLY = 32'h0000_008D
) (
  input wire logic read_enable_tag,
  input wire logic [7:0] seed,
  input wire logic flip_data,
  input wire logic flip_ecc,
  output logic drive_servo_clock,
  output logic drive_read_clock,
  output logic drive_read_data
);
  localparam logic [7:0] SYNC = `DWCS_SYNC_BYTE;
  logic [31:0] crc;
  logic [7:0] bv;
  logic framing;
  function automatic logic [7:0] byte_val(input int i, input logic [7:0] s);
    return i[7:0] ^ s ^ {i[8], 7'h00};
  endfunction : byte_val
  task automatic send_bit(input logic b);
    drive_read_data = b;
    #80 drive_read_clock = 1'b1;
    #80 drive_read_clock = 1'b0;
  endtask : send_bit
  initial begin
    drive_servo_clock = 1'b0;
    drive_read_clock = 1'b0;
    drive_read_data = 1'b0;
    framing = 1'b0;
  end
  always #80 drive_servo_clock = ~drive_servo_clock;
  // outside a frame the data line never holds its last bit
  always #35 if (!framing) drive_read_data = ~drive_read_data;
  always begin
    @(negedge read_enable_tag);
    @(posedge read_enable_tag);
    repeat (96) @(posedge drive_servo_clock);
    framing = 1'b1;
    crc = 32'h0000_0000;
    repeat (8) send_bit(1'b0);
    for (int k = 0; k < 8; k++) send_bit(SYNC[k]);
    for (int i = 0; i < `DWCS_SECTOR_BYTES * 8; i++) begin
      bv = byte_val(i / 8, seed);
      crc = {crc[30:0], 1'b0} ^ ((crc[31] ^ bv[i % 8]) ? ECC_POLY : 32'h0000_0000);
      send_bit(bv[i % 8] ^ (flip_data && i == 1000));
    end
    for (int j = 31; j >= 0; j--) send_bit(crc[j] ^ (flip_ecc && j == 0));
    framing = 1'b0;
  end
endmodule : dwcs_drive_model
`default_nettype wire

// >>> dwcs_assertions.sv
/* port checker of the write-check sequencer.
   assumes it is bound to dwcs_sequencer and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
`include "dwcs_regs.svh"
module dwcs_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic drive_servo_clock,
  input wire logic sector_transfer_grant,
  input wire logic bus_request_ack,
  input wire logic bus_request_level5,
  input wire logic sector_transfer_request,
  input wire logic read_enable_tag,
  input wire dwcs_pkg::dwcs_clksel_type shift_clock_sel,
  input wire dwcs_pkg::dwcs_clksel_type sequencer_clock_sel,
  input wire logic check_byte_load
);
  logic [2:0] servo_r;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  wire logic sh_rd = shift_clock_sel == dwcs_pkg::CLK_READ;
  wire logic sq_rd = sequencer_clock_sel == dwcs_pkg::CLK_READ;
  wire logic sh_sv = shift_clock_sel == dwcs_pkg::CLK_SERVO;
  wire logic sq_sv = sequencer_clock_sel == dwcs_pkg::CLK_SERVO;
  wire logic cpu = shift_clock_sel == dwcs_pkg::CLK_CPU
                   && sequencer_clock_sel == dwcs_pkg::CLK_CPU;
  wire logic srise = servo_r[1] && !servo_r[2];
  // servo edges counted since the read gate came back
  assign cnt_nxt = !read_enable_tag ? 8'h00 : cnt_r + {7'h00, srise && cnt_r != 8'hff};
  always_ff @(posedge clock) begin
    servo_r <= {servo_r[1:0], drive_servo_clock};
    cnt_r <= rst ? 8'h00 : cnt_nxt;
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  req_clear_a: assert property (
    sector_transfer_request && sector_transfer_grant |=> !sector_transfer_request
  ) else $error("request not cleared by grant");
  irq_hold_a: assert property (
    bus_request_level5 && !bus_request_ack |=> bus_request_level5
  ) else $error("interrupt dropped before ack");
  irq_drop_a: assert property (
    bus_request_level5 && bus_request_ack |=> !bus_request_level5
  ) else $error("interrupt kept after ack");
  gate_servo_a: assert property (
    !read_enable_tag |-> sh_sv && sq_sv
  ) else $error("gate low without servo clock");
  lock_wait_a: assert property (
    $rose(sh_rd) |-> cnt_r >= 8'(`DWCS_LOCK_PULSES)
  ) else $error("read clock before lock wait");
  seq_stall_a: assert property (
    sq_rd |-> sh_rd
  ) else $error("sequencer clocked before shift");
  sync_load_a: assert property (
    $rose(sq_rd) |-> (check_byte_load || $past(check_byte_load) || $past(check_byte_load, 2))
      or (##[1:2] check_byte_load)
  ) else $error("sync without check-byte load");
  load_read_a: assert property (
    check_byte_load |-> sh_rd
  ) else $error("check-byte load off read clock");
  load_pulse_a: assert property (
    check_byte_load |=> !check_byte_load ##1 !check_byte_load
  ) else $error("check-byte load repeated");
  req_cpu_a: assert property (
    sector_transfer_request |-> cpu
  ) else $error("request without cpu clock");
  irq_cpu_a: assert property (
    $rose(bus_request_level5) |-> cpu
  ) else $error("interrupt without cpu clock");
  c_grant: cover property (sector_transfer_request && sector_transfer_grant);
  c_load: cover property (check_byte_load);
  c_irq: cover property ($rose(bus_request_level5));
endmodule : dwcs_checker
bind dwcs_sequencer dwcs_checker chk_u (
  .clock(clock), .rst(rst), .drive_servo_clock(drive_servo_clock),
  .sector_transfer_grant(sector_transfer_grant), .bus_request_ack(bus_request_ack),
  .bus_request_level5(bus_request_level5), .sector_transfer_request(sector_transfer_request),
  .read_enable_tag(read_enable_tag), .shift_clock_sel(shift_clock_sel),
  .sequencer_clock_sel(sequencer_clock_sel), .check_byte_load(check_byte_load)
);
`default_nettype wire

// >>> dwcs_testbench.sv
/* self-checking bench of the write-check sequencer over ahb-lite.
   assumes dwcs_drive_model as the drive and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "dwcs_regs.svh"
module testbench;
  localparam logic [31:0] A_CSR = 32'(`DWCS_OFS_CSR);
  localparam logic [31:0] A_BUF = 32'(`DWCS_OFS_BUF);
  localparam logic [31:0] A_DADDR = 32'(`DWCS_OFS_DADDR);
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic found = 1'b0;
  logic grant = 1'b0;
  logic ack = 1'b0;
  logic [7:0] seed = 8'h00;
  logic flip_d = 1'b0;
  logic flip_e = 1'b0;
  logic host_b = 1'b0;
  logic drv_ok = 1'b1;
  wire logic [31:0] timer;
  logic [31:0] rdata;
  logic [31:0] daddr;
  int mismatches = 0;
  int comparisons = 0;
  wire logic hreadyout;
  wire logic [31:0] hrdata;
  wire logic servo, rclk, rdat, irq, req, tag;
  always #10 clock = ~clock;
  dwcs_sequencer #(.GAP_PULSES(`DWCS_GAP_PULSES), .ECC_POLY(`DWCS_ECC_POLY)) dut_u (
    .clock(clock), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .drive_servo_clock(servo), .drive_read_clock(rclk), .drive_read_data(rdat),
    .sector_found(found), .drive_ready(drv_ok), .sector_transfer_grant(grant),
    .bus_request_ack(ack), .bus_request_level5(irq), .sector_transfer_request(req),
    .read_enable_tag(tag), .shift_clock_sel(), .sequencer_clock_sel(),
    .check_byte_load(), .shift_out_bit(), .function_timer(timer)
  );
  dwcs_drive_model #(.ECC_POLY(`DWCS_ECC_POLY)) drive_u (
    .read_enable_tag(tag), .seed(seed), .flip_data(flip_d), .flip_ecc(flip_e),
    .drive_servo_clock(servo), .drive_read_clock(rclk), .drive_read_data(rdat)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  task automatic wait_ready();
    @(posedge clock);
    while (hreadyout !== 1'b1) begin
      @(posedge clock);
    end
  endtask : wait_ready
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rdata = hrdata;
  endtask : bus
  task automatic csr_is(input logic [31:0] mask, input logic [31:0] exp);
    bus(1'b0, A_CSR, 32'h0000_0000);
    check(rdata & mask, exp);
  endtask : csr_is
  task automatic wait_out(input logic want_irq);
    int n;
    n = 0;
    while ((want_irq ? irq : req) !== 1'b1 && n < 45000) begin
      @(posedge clock);
      n++;
    end
    check({31'h0, n < 45000}, 32'h0000_0001);
  endtask : wait_out
  task automatic pulse_found();
    found <= 1'b1;
    repeat (6) @(posedge clock);
    found <= 1'b0;
    @(posedge clock);
  endtask : pulse_found
  task automatic do_grant();
    grant <= 1'b1;
    @(posedge clock);
    grant <= 1'b0;
    repeat (2) @(posedge clock);
    check({31'h0, req}, 32'h0000_0000);
  endtask : do_grant
  task automatic ack_irq();
    repeat (4) @(posedge clock);
    check({31'h0, irq}, 32'h0000_0001);
    ack <= 1'b1;
    @(posedge clock);
    ack <= 1'b0;
    repeat (2) @(posedge clock);
    check({31'h0, irq}, 32'h0000_0000);
  endtask : ack_irq
  task automatic load_buf(input logic [7:0] s, input logic other, input logic rdy);
    bus(1'b0, A_CSR, 32'h0000_0000);
    host_b = rdata[6] ^ other;
    bus(1'b1, A_CSR, {24'h00_0000, host_b, 6'h01, rdy});
    for (int i = 0; i < `DWCS_SECTOR_BYTES; i++) begin
      bus(1'b1, A_BUF, {24'h00_0000, drive_u.byte_val(i, s)});
    end
    bus(1'b0, A_CSR, 32'h0000_0000);
    check({31'h0, rdata[8 + host_b]}, 32'h0000_0001);
  endtask : load_buf
  task automatic start_check();
    bus(1'b1, A_CSR, {24'h00_0000, host_b, 7'h02});
    pulse_found();
  endtask : start_check
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    csr_is(32'hffff_ffff, `DWCS_CSR_RESET);
    bus(1'b0, 32'h0000_000C, 32'h0000_0000);
    check(rdata, 32'h0000_0000);
    start_check();
    wait_out(1'b1);
    csr_is(32'h0000_001D, 32'h0000_0011);
    check({31'h0, tag}, 32'h0000_0001);
    ack_irq();
    load_buf(8'h3c, 1'b0, 1'b1);
    seed <= 8'h3c;
    start_check();
    load_buf(8'ha5, 1'b1, 1'b0);
    wait_out(1'b0);
    csr_is(32'h0000_002D, 32'h0000_0024);
    check({31'h0, irq}, 32'h0000_0000);
    drv_ok <= 1'b0;
    bus(1'b0, A_DADDR, 32'h0000_0000);
    daddr = rdata;
    seed <= 8'ha5;
    flip_e <= 1'b1;
    do_grant();
    check({31'h0, timer < 32'h0000_0008}, 32'h0000_0001);
    pulse_found();
    check({31'h0, tag}, 32'h0000_0001);
    drv_ok <= 1'b1;
    repeat (4) @(posedge clock);
    pulse_found();
    bus(1'b0, A_DADDR, 32'h0000_0000);
    check(rdata, daddr + 32'h0000_0001);
    bus(1'b0, A_CSR, 32'h0000_0000);
    check({31'h0, rdata[6]}, {31'h0, host_b});
    wait_out(1'b1);
    csr_is(32'h0000_002D, 32'h0000_000D);
    ack_irq();
    load_buf(8'h5a, 1'b0, 1'b1);
    seed <= 8'h5a;
    flip_e <= 1'b0;
    flip_d <= 1'b1;
    start_check();
    wait_out(1'b0);
    csr_is(32'h0000_002D, 32'h0000_0020);
    bus(1'b1, A_CSR, 32'h0000_0003);
    do_grant();
    wait_out(1'b1);
    csr_is(32'h0000_0021, 32'h0000_0001);
    ack_irq();
    print_verdict();
  end
  initial begin
    repeat (110000) @(posedge clock);
    mismatches++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
